// ==== shared/uabd_pkg.sv ====
package uabd_pkg;

   // ==========================================
   // counter and divider sizing
   localparam int unsigned CNT_W = 16;
   localparam int unsigned DIV_W = 9;
   localparam logic [CNT_W-1:0] CNT_START = 16'h0001;
   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
   localparam logic [7:0] HIGH_ZERO = 8'h00;

   // ==========================================
   // auto-baud tick periods in system clocks (Fosc/512, /128, /32)
   localparam logic [DIV_W-1:0] DIV_SLOW = 9'h1ff;
   localparam logic [DIV_W-1:0] DIV_MID = 9'h07f;
   localparam logic [DIV_W-1:0] DIV_FAST = 9'h01f;
   localparam logic [DIV_W-1:0] DIV_ZERO = 9'h000;

   // five rising edges of the sync character, the first starts the count
   localparam logic [2:0] EDGE_LAST = 3'h4;
   localparam logic [2:0] EDGE_ZERO = 3'h0;

   // the serial line idles high
   localparam logic LINE_IDLE = 1'b1;

   typedef enum logic [2:0]
   {
      UABD_IDLE,
      UABD_WAIT_BREAK,
      UABD_WAIT_START,
      UABD_WAIT_RISE,
      UABD_COUNT
   } uabd_state_t;

endpackage : uabd_pkg

// ==== design/uabd_sync.sv ====
`timescale 1ns/1ns
`default_nettype none

module uabd_sync
   import uabd_pkg::*;
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   // line in and filtered out
   input wire logic i_line,
   output logic o_line
);

   logic s1;
   logic s2;
   logic s3;
   logic line;
   logic next_line;

   // a change counts once the second and third stages agree
   always_comb
   begin
      next_line = line;
      if (s2 == s3)
      begin
         next_line = s3;
      end
   end

   // reset to idle-high so no false falling edge at release
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         s1 <= LINE_IDLE;
         s2 <= LINE_IDLE;
         s3 <= LINE_IDLE;
         line <= LINE_IDLE;
      end
      else
      begin
         s1 <= i_line;
         s2 <= s1;
         s3 <= s2;
         line <= next_line;
      end
   end

   assign o_line = line;

endmodule : uabd_sync

`default_nettype wire

// ==== design/uabd_tick.sv ====
`timescale 1ns/1ns
`default_nettype none

module uabd_tick
   import uabd_pkg::*;
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   // restart and rate select
   input wire logic i_restart,
   input wire logic i_wide_rate_select,
   input wire logic i_fast_rate_select,
   // one-cycle tick at the auto-baud clock rate
   output logic o_tick
);

   logic [DIV_W-1:0] cnt;
   logic [DIV_W-1:0] next_cnt;
   logic [DIV_W-1:0] period;

   // ==========================================
   // tick period select
   function automatic logic [DIV_W-1:0] sel_period(input logic wide, input logic fast);
      logic [1:0] sel;
      sel = {wide, fast};
      case (sel)
         2'h0: sel_period = DIV_SLOW;
         2'h3: sel_period = DIV_FAST;
         default: sel_period = DIV_MID;
      endcase
   endfunction : sel_period

   assign period = sel_period(i_wide_rate_select, i_fast_rate_select);

   always_comb
   begin
      next_cnt = cnt + 9'h001;
      if (i_restart || cnt >= period)
      begin
         next_cnt = DIV_ZERO;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cnt <= DIV_ZERO;
      end
      else
      begin
         cnt <= next_cnt;
      end
   end

   assign o_tick = !i_restart && (cnt == period);

endmodule : uabd_tick

`default_nettype wire

// ==== design/uabd_detect.sv ====
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - A write of one to the arm bit starts calibration, with the line timing the counter.
// - The receiver's main state machine is held idle while calibration runs.
// - Counting begins at the first rising edge after the start bit.
// - At the fifth rising edge counting stops, the arm bit clears and the receive flag sets.
// - Reading the receive holding register clears the receive flag, the value is discarded.
// - Both rate registers form one 16-bit counter during calibration regardless of width mode.
// - The counter advances at one eighth of the normal rate-generator base clock.
// - Auto-baud clock is Fosc/512, Fosc/128 or Fosc/32 by the two rate-select bits.
// - With wake-on-break set, measurement uses the character after the break.
// - The counter starts at one and software may subtract one from the result.
module uabd_detect
   import uabd_pkg::*;
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   // receive pin
   input wire logic i_rx,
   // software control of the baud control register
   input wire logic i_autobaud_arm_set,
   input wire logic i_wake_on_break,
   input wire logic i_wide_rate_select,
   input wire logic i_fast_rate_select,
   // software read of the receive holding register
   input wire logic i_receive_holding_read,
   // status
   output logic o_autobaud_arm,
   output logic o_autobaud_mode,
   output logic o_receive_flag,
   output logic o_rx_hold_idle,
   output logic o_low_overflow,
   // measured period
   output logic [7:0] o_rate_count_high,
   output logic [7:0] o_rate_count_low
);

   // ==========================================
   // receive line conditioning
   logic line;
   logic line_q;
   logic rise;
   logic fall;
   logic tick;

   uabd_sync u_sync
   (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(i_rst_n),
      .i_line(i_rx),
      .o_line(line)
   );

   assign rise = line && !line_q;
   assign fall = !line && line_q;

   // ==========================================
   // calibration state
   uabd_state_t state;
   uabd_state_t next_state;
   logic arm;
   logic next_arm;
   logic flag;
   logic next_flag;
   logic hold;
   logic next_hold;
   logic [2:0] edges;
   logic [2:0] next_edges;
   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] next_count;
   logic ovf;
   logic next_ovf;
   logic done;

   uabd_tick u_tick
   (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(i_rst_n),
      .i_restart(state != UABD_COUNT),
      .i_wide_rate_select(i_wide_rate_select),
      .i_fast_rate_select(i_fast_rate_select),
      .o_tick(tick)
   );

   assign done = (state == UABD_COUNT) && rise && (edges == EDGE_LAST);

   always_comb
   begin
      next_state = state;
      next_arm = arm;
      next_edges = edges;
      next_count = count;
      next_ovf = ovf;
      case (state)
         UABD_IDLE:
         begin
            if (i_autobaud_arm_set)
            begin
               next_arm = 1'b1;
               next_state = i_wake_on_break ? UABD_WAIT_BREAK : UABD_WAIT_START;
            end
         end
         UABD_WAIT_BREAK:
         begin
            // the break ends on its rising edge; the sync start bit follows
            if (rise)
            begin
               next_state = UABD_WAIT_START;
            end
         end
         UABD_WAIT_START:
         begin
            if (fall)
            begin
               next_state = UABD_WAIT_RISE;
            end
         end
         UABD_WAIT_RISE:
         begin
            if (rise)
            begin
               next_count = CNT_START;
               next_edges = EDGE_ZERO + 3'h1;
               next_ovf = 1'b0;
               next_state = UABD_COUNT;
            end
         end
         UABD_COUNT:
         begin
            if (tick)
            begin
               next_count = count + 16'h0001;
               if (count[7:0] == 8'hff)
               begin
                  next_ovf = 1'b1;
               end
            end
            if (rise)
            begin
               next_edges = edges + 3'h1;
            end
            if (done)
            begin
               next_count = count;
               // a tick on the stop edge must not flag a wrap that never lands
               next_ovf = ovf;
               next_arm = 1'b0;
               next_edges = EDGE_ZERO;
               next_state = UABD_IDLE;
            end
         end
         default:
         begin
            next_state = UABD_IDLE;
            next_arm = 1'b0;
         end
      endcase
   end

   always_comb
   begin
      next_flag = flag;
      if (i_receive_holding_read)
      begin
         next_flag = 1'b0;
      end
      if (done)
      begin
         next_flag = 1'b1;
      end
   end

   always_comb
   begin
      next_hold = (next_state != UABD_IDLE);
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         state <= UABD_IDLE;
         arm <= 1'b0;
         flag <= 1'b0;
         hold <= 1'b0;
         edges <= EDGE_ZERO;
         count <= CNT_ZERO;
         ovf <= 1'b0;
         line_q <= LINE_IDLE;
      end
      else
      begin
         state <= next_state;
         arm <= next_arm;
         flag <= next_flag;
         hold <= next_hold;
         edges <= next_edges;
         count <= next_count;
         ovf <= next_ovf;
         line_q <= line;
      end
   end

   // ==========================================
   // outputs, all from flip-flops
   assign o_autobaud_arm = arm;
   assign o_autobaud_mode = hold;
   assign o_receive_flag = flag;
   assign o_rx_hold_idle = hold;
   // overflow visible as nonzero high byte
   assign o_low_overflow = ovf;
   assign o_rate_count_high = count[15:8];
   assign o_rate_count_low = count[7:0];

   // ==========================================
   // checks
   sequence s_arm_req;
      (state == UABD_IDLE) && i_autobaud_arm_set;
   endsequence

   sequence s_fifth_rise;
      done;
   endsequence

   // ticks with both rate-select bits set, or with exactly one set
   sequence s_tick_fast;
      tick && i_wide_rate_select && i_fast_rate_select;
   endsequence

   sequence s_tick_mid;
      tick && (i_wide_rate_select != i_fast_rate_select);
   endsequence

   AST_ARM_STARTS: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      s_arm_req |=> arm && hold)
      else $error("arm did not start calibration");

   AST_HOLD_IDLE: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (state != UABD_IDLE) |-> ##1 (hold == (state != UABD_IDLE) || $past(done)))
      else $error("receiver not held idle");

   AST_COUNT_START: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (state == UABD_WAIT_RISE) && rise |=> (count == CNT_START) && (state == UABD_COUNT))
      else $error("count did not start at one on first rise");

   AST_DONE: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      s_fifth_rise |=> !arm && flag && (count == $past(count)) && !hold)
      else $error("completion did not clear arm and set flag");

   AST_READ_CLR: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      i_receive_holding_read && !done |=> !flag)
      else $error("read did not clear receive flag");

   AST_WIDE: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (state == UABD_COUNT) && tick && !done && count == 16'h00ff |=> count == 16'h0100)
      else $error("count not carried into high byte");

   AST_TICK_ONLY: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (state == UABD_COUNT) && !tick && !done |=> $stable(count))
      else $error("count moved without tick");

   AST_TICK_SPACE: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      tick |=> !tick [*8])
      else $error("ticks too close");

   AST_BREAK: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (s_arm_req and i_wake_on_break) |=> state == UABD_WAIT_BREAK)
      else $error("wake on break not honoured");

   AST_EDGE_RANGE: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (state == UABD_COUNT) |-> (edges != EDGE_ZERO) && (edges <= EDGE_LAST))
      else $error("rising edge count out of range while counting");

   AST_OVF_HIGH: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      s_fifth_rise |=> ovf == (count[15:8] != HIGH_ZERO))
      else $error("overflow status disagrees with high byte");

   AST_FAST_GAP: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      s_tick_fast |-> ##32 (tick || (state != UABD_COUNT)))
      else $error("fast tick period wrong");

   AST_MID_GAP: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      s_tick_mid |-> ##128 (tick || (state != UABD_COUNT)))
      else $error("middle tick period wrong");

   AST_BREAK_WAIT: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (state == UABD_WAIT_BREAK) && !rise |=> state == UABD_WAIT_BREAK)
      else $error("left break wait without a rising edge");

   AST_ARM_IGNORED: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (state == UABD_COUNT) && i_autobaud_arm_set && !done |=> (state == UABD_COUNT))
      else $error("arm while busy disturbed the measurement");

endmodule : uabd_detect

`default_nettype wire

// ==== testbench/uabd_far_tx.sv ====
`timescale 1ns/1ns
`default_nettype none

module uabd_far_tx
(
   // clock
   input wire logic i_ref_clk,
   // frame request
   input wire logic i_send,
   input wire logic i_break,
   input wire logic [15:0] i_bit_clks,
   // serial line
   output logic o_line,
   output logic o_busy
);
   logic [9:0] frame;

   // ==========================================
   // transmitter
   initial
   begin
      o_line = 1'b1;
      o_busy = 1'b0;
      forever
      begin
         @(posedge i_ref_clk);
         if (i_send)
         begin
            o_busy <= 1'b1;
            if (i_break)
            begin
               o_line <= 1'b0;
               repeat (13 * i_bit_clks) @(posedge i_ref_clk);
               o_line <= 1'b1;
               repeat (2 * i_bit_clks) @(posedge i_ref_clk);
            end
            frame = {1'b1, 8'h55, 1'b0};
            for (int i = 0; i < 10; i++)
            begin
               o_line <= frame[i];
               repeat (i_bit_clks) @(posedge i_ref_clk);
            end
            o_busy <= 1'b0;
         end
      end
   end
endmodule : uabd_far_tx

`default_nettype wire

// ==== testbench/uabd_detect_bench.sv ====
`timescale 1ns/1ns
`default_nettype none

module uabd_detect_bench;
   import uabd_pkg::*;

   logic i_ref_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_arm = 1'b0;
   logic i_wob = 1'b0;
   logic i_wide = 1'b0;
   logic i_fast = 1'b0;
   logic i_read = 1'b0;
   logic send = 1'b0;
   logic brk = 1'b0;
   logic [15:0] bit_clks = 16'h0020;
   logic rx;
   logic busy;
   logic arm;
   logic mode;
   logic flag;
   logic hold;
   logic ovf;
   logic [7:0] cnt_h;
   logic [7:0] cnt_l;
   int n_mismatch = 0;
   int comparisons = 0;
   int cycles = 0;

   uabd_detect i_uabd_detect (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_rx(rx),
      .i_autobaud_arm_set(i_arm), .i_wake_on_break(i_wob), .i_wide_rate_select(i_wide),
      .i_fast_rate_select(i_fast), .i_receive_holding_read(i_read), .o_autobaud_arm(arm),
      .o_autobaud_mode(mode), .o_receive_flag(flag), .o_rx_hold_idle(hold),
      .o_low_overflow(ovf), .o_rate_count_high(cnt_h), .o_rate_count_low(cnt_l));

   uabd_far_tx i_uabd_far_tx (.i_ref_clk(i_ref_clk), .i_send(send), .i_break(brk),
      .i_bit_clks(bit_clks), .o_line(rx), .o_busy(busy));

   // ==========================================
   // clock, timeout, reporting
   initial
   begin
      forever #50 i_ref_clk = ~i_ref_clk;
   end

   always @(posedge i_ref_clk)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         n_mismatch++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      if (n_mismatch == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : tally_and_finish

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // ==========================================
   // one measurement; the eight-bit measured span sits half a tick off any tick boundary
   task automatic measure(input logic w, input logic f, input logic b,
      input logic [15:0] bc, input logic [15:0] exp, input logic exp_ovf);
      @(posedge i_ref_clk);
      i_wide <= w;
      i_fast <= f;
      i_wob <= b;
      i_arm <= 1'b1;
      @(posedge i_ref_clk);
      i_arm <= 1'b0;
      #1;
      check(arm, 1'b1);
      check(hold, 1'b1);
      check(mode, 1'b1);
      @(posedge i_ref_clk);
      brk <= b;
      bit_clks <= bc;
      send <= 1'b1;
      @(posedge i_ref_clk);
      send <= 1'b0;
      // a second arm mid-measurement must not restart anything
      repeat (3 * bc) @(posedge i_ref_clk);
      i_arm <= 1'b1;
      @(posedge i_ref_clk);
      i_arm <= 1'b0;
      while (flag !== 1'b1) @(posedge i_ref_clk);
      #1;
      check(arm, 1'b0);
      check(hold, 1'b0);
      check(mode, 1'b0);
      check({cnt_h, cnt_l}, exp);
      check(ovf, exp_ovf);
      @(posedge i_ref_clk);
      i_read <= 1'b1;
      @(posedge i_ref_clk);
      i_read <= 1'b0;
      #1;
      check(flag, 1'b0);
      check({cnt_h, cnt_l}, exp);
      while (busy !== 1'b0) @(posedge i_ref_clk);
   endtask : measure

   // ==========================================
   // scenarios
   task automatic test_rate_selects();
      // count = 1 + 10 ticks at 512/128/128/32 clocks, 8 bits = 10.5 ticks
      measure(1'b0, 1'b0, 1'b0, 16'd672, 16'h000b, 1'b0);
      measure(1'b0, 1'b1, 1'b0, 16'd168, 16'h000b, 1'b0);
      measure(1'b1, 1'b0, 1'b0, 16'd168, 16'h000b, 1'b0);
      measure(1'b1, 1'b1, 1'b0, 16'd42, 16'h000b, 1'b0);
   endtask : test_rate_selects

   task automatic test_break();
      measure(1'b1, 1'b0, 1'b1, 16'd168, 16'h000b, 1'b0);
   endtask : test_break

   task automatic test_overflow();
      // 300.5 ticks at 32 clocks, count carries into the high byte
      measure(1'b1, 1'b1, 1'b0, 16'd1202, 16'h012d, 1'b1);
   endtask : test_overflow

   // reset in mid-count clears the measurement, then a clean one follows
   task automatic test_reset_midrun();
      @(posedge i_ref_clk);
      i_wide <= 1'b1;
      i_fast <= 1'b1;
      i_wob <= 1'b0;
      i_arm <= 1'b1;
      @(posedge i_ref_clk);
      i_arm <= 1'b0;
      bit_clks <= 16'd42;
      send <= 1'b1;
      @(posedge i_ref_clk);
      send <= 1'b0;
      repeat (200) @(posedge i_ref_clk);
      check(hold, 1'b1);
      i_rst_n <= 1'b0;
      repeat (2) @(posedge i_ref_clk);
      #1;
      check(arm, 1'b0);
      check(hold, 1'b0);
      check({cnt_h, cnt_l}, CNT_ZERO);
      @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      repeat (2) @(posedge i_ref_clk);
      #1;
      check(arm, 1'b0);
      check(flag, 1'b0);
      while (busy !== 1'b0) @(posedge i_ref_clk);
      measure(1'b1, 1'b1, 1'b0, 16'd42, 16'h000b, 1'b0);
   endtask : test_reset_midrun

   initial
   begin
      repeat (20) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      #1;
      check(flag, 1'b0);
      check(arm, 1'b0);
      test_rate_selects();
      test_break();
      test_overflow();
      test_reset_midrun();
      tally_and_finish();
   end
endmodule : uabd_detect_bench

`default_nettype wire
